// ### logic/trig_pkg.sv
// constants and types for the trigger output unit control block
package trig_pkg;
  localparam int UNITS = 4;
  localparam int ADDR_W = 12;
  // register byte addresses
  localparam logic [11:0] OFS_INDEX = 12'h500;
  localparam logic [11:0] OFS_CSR = 12'h504;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h508;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h50c;
  localparam logic [11:0] OFS_CTL1 = 12'h538;
  // control one field positions
  localparam int B_CHAIN = 31;
  localparam int B_TAIL = 30;
  localparam int B_SEL_HI = 27;
  localparam int B_SEL_LO = 26;
  localparam int B_NOW = 25;
  localparam int B_NOTIFY = 24;
  localparam int B_EDGE = 23;
  // control and status fields
  localparam int B_ACTIVE = 4;
  localparam int B_ENABLE = 3;
  localparam int B_SOFT_CLEAR = 2;
  // status/mask layout: finished flags low nibble, fault flags next
  localparam int B_DONE_LO = 0;
  localparam int B_FAULT_LO = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic chain_enable;
    logic tail;
    logic [1:0] upstream_sel;
    logic fire_now;
    logic notify;
    logic neg_edge;
  } unit_ctl_s;
endpackage : trig_pkg

// ### logic/trig_launch.sv
// output launcher: registers a fire pulse on the chosen clock edge
`timescale 1ns/100ps
`default_nettype none
module trig_launch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic fire,
  input wire logic neg_edge,
  output logic out
);
  logic pos_q;
  logic neg_q;

  // rising-edge copy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_q <= 1'b0;
    end else if (ce) begin
      pos_q <= fire;
    end
  end

  // falling-edge copy re-times the rising copy half a period later; the
  // fire input is only valid up to the rising edge, so it cannot be used
  always_ff @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      neg_q <= 1'b0;
    end else if (ce) begin
      neg_q <= pos_q;
    end
  end

  assign out = neg_edge ? neg_q : pos_q;
endmodule : trig_launch
`default_nettype wire

// ### logic/trig_ctl.sv
// trigger output unit control: indexed control, chaining and status
`timescale 1ns/100ps
`default_nettype none
module trig_ctl
  import trig_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic [UNITS-1:0] target_reached,
  input wire logic [UNITS-1:0] target_past,
  output logic [UNITS-1:0] trig_out,
  output logic irq
);
  typedef struct packed {
    unit_ctl_s [UNITS-1:0] ctl;
    logic [UNITS-1:0] armed;
    logic [1:0] index;
    logic [UNITS-1:0] finished;
    logic [UNITS-1:0] fault;
    logic [2*UNITS-1:0] mask;
    logic [31:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [UNITS-1:0] fire_c;
  logic [UNITS-1:0] fault_c;
  logic [UNITS-1:0] start_c;
  logic [UNITS-1:0] dclr;
  logic [UNITS-1:0] fclr;

  // pack one unit's control fields into the register word
  function automatic logic [31:0] ctl_word(input unit_ctl_s c);
    logic [31:0] w;
    w = RESET_WORD;
    w[B_CHAIN] = c.chain_enable;
    w[B_TAIL] = c.tail;
    w[B_SEL_HI:B_SEL_LO] = c.upstream_sel;
    w[B_NOW] = c.fire_now;
    w[B_NOTIFY] = c.notify;
    w[B_EDGE] = c.neg_edge;
    return w;
  endfunction : ctl_word

  // unit events: a fire or a fault ends the armed state
  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      fire_c[u] = s_q.armed[u] & (target_reached[u]
                  | (s_q.ctl[u].fire_now & target_past[u]));
      fault_c[u] = s_q.armed[u] & target_past[u] & ~target_reached[u]
                   & ~s_q.ctl[u].fire_now;
    end
  end

  // chaining: upstream finish starts a unit unless that upstream is tail or is unit 0;
  // with no tail in a ring the finish keeps passing round forever
  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      start_c[u] = 1'b0;
      if (s_q.ctl[u].chain_enable && s_q.ctl[u].upstream_sel != 2'h0) begin
        start_c[u] = fire_c[s_q.ctl[u].upstream_sel]
                     & ~s_q.ctl[s_q.ctl[u].upstream_sel].tail;
      end
    end
  end

  // write-one-to-clear decode for the sticky status flags
  assign dclr = (wr_stb && addr == OFS_IRQ_STAT) ?
                wdata[B_DONE_LO+UNITS-1:B_DONE_LO] : '0;
  assign fclr = (wr_stb && addr == OFS_IRQ_STAT) ?
                wdata[B_FAULT_LO+UNITS-1:B_FAULT_LO] : '0;

  // next-state logic for every register of the block
  always_comb begin
    s_d = s_q;
    s_d.rdata = RESET_WORD;
    for (int u = 0; u < UNITS; u++) begin
      if (fire_c[u] || fault_c[u]) begin
        s_d.armed[u] = 1'b0;
      end
      if (start_c[u]) begin
        s_d.armed[u] = 1'b1;
      end
      // set beats clear on the sticky flags; notify gates both
      s_d.finished[u] = (s_q.finished[u] & ~dclr[u])
                        | (fire_c[u] & s_q.ctl[u].notify);
      s_d.fault[u] = (s_q.fault[u] & ~fclr[u])
                     | (fault_c[u] & s_q.ctl[u].notify);
    end
    if (wr_stb) begin
      unique case (addr)
        OFS_INDEX: s_d.index = wdata[1:0];
        OFS_IRQ_MASK: s_d.mask = wdata[2*UNITS-1:0];
        OFS_CTL1: begin
          s_d.ctl[s_q.index].chain_enable = wdata[B_CHAIN];
          s_d.ctl[s_q.index].tail = wdata[B_TAIL];
          s_d.ctl[s_q.index].upstream_sel = wdata[B_SEL_HI:B_SEL_LO];
          s_d.ctl[s_q.index].fire_now = wdata[B_NOW];
          s_d.ctl[s_q.index].notify = wdata[B_NOTIFY];
          s_d.ctl[s_q.index].neg_edge = wdata[B_EDGE];
        end
        OFS_CSR: begin
          if (wdata[B_SOFT_CLEAR]) begin
            // soft clear wins over a same-cycle enable
            s_d.ctl[s_q.index] = '0;
            s_d.armed[s_q.index] = 1'b0;
          end else if (wdata[B_ENABLE]) begin
            s_d.armed[s_q.index] = 1'b1;
          end else if (!start_c[s_q.index]) begin
            s_d.armed[s_q.index] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        OFS_INDEX: s_d.rdata[1:0] = s_q.index;
        OFS_IRQ_MASK: s_d.rdata[2*UNITS-1:0] = s_q.mask;
        OFS_IRQ_STAT: begin
          s_d.rdata[B_DONE_LO+UNITS-1:B_DONE_LO] = s_q.finished;
          s_d.rdata[B_FAULT_LO+UNITS-1:B_FAULT_LO] = s_q.fault;
        end
        OFS_CTL1: s_d.rdata = ctl_word(s_q.ctl[s_q.index]);
        OFS_CSR: begin
          s_d.rdata[B_ACTIVE] = s_q.armed[s_q.index];
          s_d.rdata[B_ENABLE] = s_q.armed[s_q.index];
        end
        default: ; // unmapped reads return zero
      endcase
    end
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  // level interrupt while any unmasked flag is set
  assign irq = |({s_q.fault, s_q.finished} & s_q.mask);

  // one launcher per unit
  for (genvar g = 0; g < UNITS; g++) begin : g_launch
    trig_launch u_launch (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .fire(fire_c[g]),
      .neg_edge(s_q.ctl[g].neg_edge),
      .out(trig_out[g])
    );
  end
endmodule : trig_ctl
`default_nettype wire

// ### tb/trig_ctl_props.sv
// checker of trig_ctl register port and output timing
`timescale 1ns/100ps
`default_nettype none
module trig_ctl_props
  import trig_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic [UNITS-1:0] target_reached,
  input wire logic [UNITS-1:0] target_past,
  input wire logic [UNITS-1:0] trig_out,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [UNITS-1:0] hit;
  // any reason a unit may fire or fault
  assign hit = target_reached | target_past;
  property p_rst; $fell(sys_rst) |-> rdata == 32'h0 && !irq; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_idle; !$past(rd_stb) |-> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata leak");
  property p_rsvd; $past(rd_stb) && $past(addr) == OFS_CTL1
    |-> (rdata & 32'h307f_ffff) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  property p_back; wr_stb && addr == OFS_CTL1 ##1 rd_stb && addr == OFS_CTL1
    |=> rdata == ($past(wdata, 2) & 32'hcf80_0000); endproperty
  a_back: assert property (p_back) else $error("ctl readback");
  // a self-clearing enable allows only single pulses
  property p_pulse; (trig_out & $past(trig_out)) == 4'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_cause; (trig_out & ~$past(hit)) == 4'h0; endproperty
  a_cause: assert property (p_cause) else $error("early fire");
  // irq is decoded from status with no register stage; two cycles are allowed
  property p_fall; $fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("irq dropped");
  property p_rise; $rose(irq) |-> $past(|hit) || $past(|hit, 2)
    || $past(wr_stb) || $past(wr_stb, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq no cause");
endmodule : trig_ctl_props
`default_nettype wire

// ### tb/test_trigger_output_unit_control.sv
// self-checking bench for trig_ctl
`timescale 1ns/100ps
`default_nettype none
module test_trigger_output_unit_control
  import trig_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, v[UNITS];
  logic [3:0] target_reached = 4'h0, target_past = 4'h0, trig_out;
  logic irq;
  logic [11:0] ofs[5] = '{OFS_INDEX, OFS_CSR, OFS_IRQ_STAT, OFS_IRQ_MASK,
    OFS_CTL1};
  int failures = 0, checked = 0;
  int n = 0;
  always #10 clk = ~clk;
  trig_ctl dut_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask : chk
  // strobe stays up so a following write is back to back
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    rd_stb <= 1'b0;
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd
  // unit 2 faults, unit 3 runs without notify
  function automatic logic [31:0] stat(input int k);
    return k == 2 ? 32'h40 : k == 3 ? 32'h0 : 32'h1 << k;
  endfunction : stat
  task automatic conclude;
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(32'h27f4));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    wr(12'h53c, $urandom);
    rd(12'h53c, 32'h0);
    // all-ones corner on the last unit
    for (int u = 0; u < UNITS; u++) begin
      v[u] = (u == 3) ? 32'hffff_ffff : $urandom;
      wr(OFS_INDEX, u);
      wr(OFS_CTL1, v[u]);
      rd(OFS_CTL1, v[u] & 32'hcf80_0000);
    end
    for (int u = 0; u < UNITS; u++) begin
      wr(OFS_INDEX, u);
      rd(OFS_CTL1, v[u] & 32'hcf80_0000);
    end
    wr(OFS_IRQ_MASK, 32'hff);
    for (int k = 0; k < UNITS; k++) begin
      wr(OFS_INDEX, k);
      wr(OFS_CSR, 32'h4);
      rd(OFS_CTL1, 32'h0);
      wr(OFS_CTL1, 32'(k != 3) << 24 | 32'(k == 1) << 25 | $urandom & 32'h80_0000);
      wr(OFS_CSR, 32'h8);
      @(posedge clk);
      wr_stb <= 1'b0;
      target_reached[k] <= k == 0 || k == 3;
      target_past[k] <= k == 1 || k == 2;
      @(posedge clk);
      target_reached <= 4'h0;
      target_past <= 4'h0;
      #15 chk(trig_out, 32'(k != 2) << k);
      rd(OFS_IRQ_STAT, stat(k));
      chk(irq, 32'(k != 3));
      wr(OFS_IRQ_STAT, 32'hff);
      rd(OFS_IRQ_STAT, 32'h0);
      chk(irq, 32'h0);
    end
    // ring of units 1..3: first with unit 3 as tail, then with no tail
    for (int t = 0; t < 2; t++) begin
      for (int u = 1; u < UNITS; u++) begin
        wr(OFS_INDEX, u);
        wr(OFS_CTL1, 32'h8000_0000 | 32'(t == 0 && u == 3) << 30
           | 32'((u + 1) % 3 + 1) << 26);
      end
      wr(OFS_INDEX, 1);
      wr(OFS_CSR, 32'h8);
      @(posedge clk);
      wr_stb <= 1'b0;
      target_reached <= 4'he;
      n = 0;
      repeat (9) begin
        @(posedge clk);
        #1 n += $countones(trig_out);
      end
      chk(n, t == 0 ? 32'h3 : 32'h9);
      if (t == 1) begin
        for (int u = 1; u < UNITS; u++) begin
          wr(OFS_INDEX, u);
          wr(OFS_CSR, 32'h4);
        end
        @(posedge clk);
        wr_stb <= 1'b0;
        target_reached <= 4'h0;
        repeat (2) @(posedge clk);
        n = 0;
        repeat (6) begin
          @(posedge clk);
          #1 n += $countones(trig_out);
        end
        chk(n, 32'h0);
      end
    end
    conclude();
  end
endmodule : test_trigger_output_unit_control
bind trig_ctl trig_ctl_props props_u (.*);
`default_nettype wire
